// File: shared/frspc_map.vh
/*
  Constants of the rate, swap and power control block: register offsets,
  field positions, reset values, state codes and timing counts.
  Assumes a 250 MHz clock and a 32-bit AXI4-Lite register bus.
*/
// Contract
// - AT mode: density high at 500 Kbps or faster, low at 300/250 Kbps.
// - PS/2 mode: density is the inverse of the AT value for the rate code.
// - Data rate comes from rate table and rate code; table 11 reserved.
// - Swap field 01 or 10 moves the floppy interface to the printer pins.
// - While swapped, control writes blocked; data writes stored but inert.
// - While swapped, control and status reads give cable-absent patterns.
// - Single swap: strobe and data bit 6 are inputs; drive status combined.
// - Dual swap: strobe and bit 6 carry second select and motor; native off.
// - Swapped printer DMA floats unless ECP with DMA; interrupt per setting.
// - Controller power clear enters PD from IDLE or APD; set returns IDLE.
// - Low-power request enters APD when idle; wake to BUSY clears request.
// - Auto mode enters APD after 10 ms quiet; status access restarts timer.
// - APD floats write gate, motors, write data, selects; head pins active.
// - APD holds interrupt and DMA low, PD floats both; state reported.
// - Serial power clear enters PD when idle; outputs held inactive.
// - Serial auto power-down per direction; writes, input, ring wake.
// - Ring-indicate change events stay alive during serial power-down.
// - Printer power clear stops clock, locks registers, floats outputs.
// - Printer auto power-down stops EPP or ECP clock when mode unused.
// - Strap on first DMA request pin sets default bit and IR polarity 1.
`ifndef FRSPC_MAP_VH
`define FRSPC_MAP_VH

// ==========================================================
// register offsets (byte addresses)
`define FRS_OFF_CFG      12'h000
`define FRS_OFF_PWR      12'h004
`define FRS_OFF_STAT     12'h008
`define FRS_OFF_PDATA    12'h010
`define FRS_OFF_PCTRL    12'h014
`define FRS_OFF_PSTAT    12'h018

// ==========================================================
// configuration fields
`define FRS_CFG_RATE     1:0
`define FRS_CFG_PS2      2
`define FRS_CFG_TABLE    5:4
`define FRS_CFG_SWAP     9:8
`define FRS_CFG_DMAEN    10
`define FRS_CFG_IRQLOW   11
`define FRS_CFG_IRPOL    12
`define FRS_CFG_MASK     32'h00001F37
// power fields
`define FRS_PWR_FDC      0
`define FRS_PWR_LOWREQ   1
`define FRS_PWR_FDCAUTO  2
`define FRS_PWR_SER      5:4
`define FRS_PWR_SERAPD   7:6
`define FRS_PWR_LPT      8
`define FRS_PWR_LPTAPD   9
`define FRS_PWR_RESET    32'h00000131
`define FRS_PWR_MASK     32'h000003F7

// ==========================================================
// codes
`define FRS_SWAP_SINGLE  2'b01
`define FRS_SWAP_DUAL    2'b10
`define FRS_TBL_STD      2'b00
`define FRS_TBL_3MODE    2'b01
`define FRS_TBL_TAPE     2'b10
`define FRS_ST_IDLE      2'b00
`define FRS_ST_BUSY      2'b01
`define FRS_ST_APD       2'b10
`define FRS_ST_PD        2'b11
`define FRS_MSR_READY    8'h80
`define FRS_ECR_EPP      3'b100
`define FRS_ECR_SPP      3'b000
`define FRS_ECR_PS2      3'b001
`define FRS_PCTRL_NOCBL  8'h04
`define FRS_PSTAT_NOCBL  8'h48
`define FRS_RESP_OKAY    2'b00
`define FRS_RESP_SLVERR  2'b10

// ==========================================================
// timing
`define FRS_CLK_MHZ      250
`define FRS_APD_TIME_US  10000
`define FRS_APD_CYCLES   (`FRS_APD_TIME_US * `FRS_CLK_MHZ)

`endif

// File: rtl/frspc_top.v
/*
  Rate decode, printer-port swap and power-down control for the floppy
  controller, two serial ports and the printer port, with AXI4-Lite
  registers. Assumes the controller, serial and printer cores supply
  their status as synchronous levels and one-cycle access pulses.
*/
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "frspc_map.vh"

module frspc_top #(
  parameter APD_CYCLES = `FRS_APD_CYCLES
)(
  // clock, reset, enable
  input  wire        mclk,
  input  wire        reset_n,
  input  wire        ce,
  // axi4-lite slave
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // floppy controller status
  input  wire        fdc_idle,
  input  wire [7:0]  main_status_reg,
  input  wire        fdc_int_pending,
  input  wire        head_unload_expired,
  input  wire [1:0]  fdc_motor_en,
  input  wire        fdc_status_access,
  input  wire        fdc_soft_reset,
  input  wire        fdc_irq_req,
  input  wire        fdc_drq_req,
  input  wire        fdc_sel1_n,
  input  wire        fdc_motor1_n,
  input  wire [4:0]  fdd_status_n,
  input  wire [4:0]  lpt_status_n,
  // serial cores
  input  wire [1:0]  ser_tx_empty,
  input  wire [1:0]  ser_rx_waiting,
  input  wire [1:0]  ser_tx_write,
  input  wire [1:0]  serial_input_pin,
  input  wire [1:0]  ring_indicate,
  // printer core
  input  wire [7:0]  printer_status_in,
  input  wire        epp_configured,
  input  wire        ecp_configured,
  input  wire [2:0]  ecr_mode,
  input  wire        lpt_drq_req,
  input  wire        lpt_drq_en,
  input  wire        lpt_irq_req,
  input  wire        lpt_irq_en,
  input  wire        first_dma_request_pin,
  // drive side
  output reg         density_select_out,
  output reg  [1:0]  data_rate_out,
  output reg         fdd_ctl_oe,
  output reg         fdd_head_oe,
  output reg  [4:0]  fdc_status_n,
  output reg         strobe_pin_o,
  output reg         strobe_pin_oe,
  output reg         printer_data_bit6_o,
  output reg         printer_data_bit6_oe,
  // printer side
  output reg  [7:0]  printer_data_out,
  output reg  [3:0]  printer_ctrl_out,
  output reg         lpt_out_oe,
  output reg         lpt_drq_o,
  output reg         lpt_drq_oe,
  output reg         lpt_irq_o,
  output reg         lpt_irq_oe,
  output reg         lpt_clk_en,
  output reg         epp_clk_en,
  output reg         ecp_clk_en,
  // controller system side
  output reg         controller_interrupt_o,
  output reg         controller_interrupt_oe,
  output reg         controller_dma_request_o,
  output reg         controller_dma_request_oe,
  output reg  [1:0]  fdc_power_state,
  output reg         fdc_clk_en,
  output reg         fdc_regs_ro,
  // serial side
  output reg  [1:0]  ser_clk_en,
  output reg  [1:0]  ser_regs_ro,
  output reg  [1:0]  ser_out_inactive,
  output reg  [1:0]  ser_ri_change,
  output reg         ir_rx_invert
);

  // ==========================================================
  // register bus state
  reg  [31:0] cfg;
  reg  [31:0] pwr;
  reg  [7:0]  pdata;
  reg  [3:0]  pctrl;
  reg  [11:0] aw_addr;
  reg  [31:0] w_data;
  reg         aw_held;
  reg         w_held;
  reg         regdef;
  reg         strap_done;
  reg  [1:0]  fdc_st;
  reg  [1:0]  next_fdc_st;
  reg  [21:0] apd_cnt;
  reg  [1:0]  ser_pd;
  reg  [1:0]  ser_tx_apd;
  reg  [1:0]  ser_rx_apd;
  reg  [1:0]  sin_prev;
  reg  [1:0]  ri_prev;
  reg         high_rate;
  reg  [31:0] rd_val;
  reg         rd_hit;

  wire [1:0]  swap   = cfg[`FRS_CFG_SWAP];
  wire        sw_one = (swap == `FRS_SWAP_SINGLE);
  wire        sw_two = (swap == `FRS_SWAP_DUAL);
  wire        swapped = sw_one | sw_two;
  wire        do_wr  = aw_held & w_held & ~s_axi_bvalid;
  wire        fdc_pd = (fdc_st == `FRS_ST_PD);
  wire        fdc_apd = (fdc_st == `FRS_ST_APD);
  wire        fdc_quiet = (fdc_motor_en == 2'b00) & ~fdc_int_pending &
                          (main_status_reg == `FRS_MSR_READY) & head_unload_expired;
  wire        fdc_wake = fdc_status_access | fdc_soft_reset | (|fdc_motor_en);
  wire        apd_done = (apd_cnt == APD_CYCLES[21:0] - 22'd1);
  wire        low_clr = fdc_apd & fdc_wake;
  wire        wr_cfg = do_wr & (aw_addr == `FRS_OFF_CFG);
  wire        wr_pwr = do_wr & (aw_addr == `FRS_OFF_PWR);
  wire [31:0] cfg_wr = w_data & `FRS_CFG_MASK;
  wire [1:0]  ri_tog = ring_indicate ^ ri_prev;
  wire [1:0]  sin_tog = serial_input_pin ^ sin_prev;
  wire        ecp_used = ecp_configured & (ecr_mode != `FRS_ECR_SPP) &
                         (ecr_mode != `FRS_ECR_PS2) & (ecr_mode != `FRS_ECR_EPP);
  wire        epp_used = epp_configured |
                         (ecp_configured & (ecr_mode == `FRS_ECR_EPP));

  // ==========================================================
  // density decode follows the rate code alone, so 3-mode 360 rpm stays low
  always @*
  begin
    case (cfg[`FRS_CFG_RATE])
      2'b00:   high_rate = 1'b1;
      2'b11:   high_rate = 1'b1;
      2'b01:   high_rate = 1'b0;  // faster table entries on this code stay low
      default: high_rate = 1'b0;
    endcase
  end

  // ==========================================================
  // write channel: address and data taken in either order
  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 12'h000;
      w_data        <= 32'h00000000;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `FRS_RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_addr       <= {s_axi_awaddr[11:2], 2'b00};
        aw_held       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_data       <= s_axi_wdata;
        w_held       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_wr)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == `FRS_OFF_CFG || aw_addr == `FRS_OFF_PWR ||
                         aw_addr == `FRS_OFF_PDATA || aw_addr == `FRS_OFF_PCTRL) ?
                        `FRS_RESP_OKAY : `FRS_RESP_SLVERR;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
      if (s_axi_bvalid & s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // configuration and power registers; strap caught after release
  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      cfg        <= 32'h00000000;
      pwr        <= `FRS_PWR_RESET;
      pdata      <= 8'h00;
      pctrl      <= 4'h0;
      regdef     <= 1'b0;
      strap_done <= 1'b0;
    end
    else if (ce)
    begin
      if (!strap_done)
      begin
        regdef          <= first_dma_request_pin;
        cfg[`FRS_CFG_IRPOL] <= first_dma_request_pin;
        strap_done      <= 1'b1;
      end
      else if (wr_cfg)
      begin
        // rate code and PS/2 bits are frozen while the controller is powered down; the table field is not
        cfg[31:4] <= cfg_wr[31:4];
        if (!fdc_pd)
          cfg[3:0] <= cfg_wr[3:0];
      end
      // hardware clear of the low-power request loses to a software set
      if (wr_pwr)
        pwr <= w_data & `FRS_PWR_MASK;
      else if (low_clr || (fdc_pd && pwr[`FRS_PWR_FDC]))
        pwr[`FRS_PWR_LOWREQ] <= 1'b0;
      if (do_wr && aw_addr == `FRS_OFF_PDATA && pwr[`FRS_PWR_LPT])
        pdata <= w_data[7:0];
      if (do_wr && aw_addr == `FRS_OFF_PCTRL && pwr[`FRS_PWR_LPT] && !swapped)
        pctrl <= w_data[3:0];
    end
  end

  // ==========================================================
  // read channel: one cycle from address to data
  always @*
  begin
    rd_hit = 1'b1;
    case ({s_axi_araddr[11:2], 2'b00})
      `FRS_OFF_CFG:   rd_val = cfg;
      `FRS_OFF_PWR:   rd_val = pwr;
      `FRS_OFF_STAT:  rd_val = {20'h00000, data_rate_out, density_select_out,
                                regdef, ser_rx_apd, ser_tx_apd, ser_pd, fdc_st};
      `FRS_OFF_PDATA: rd_val = {24'h000000, pdata};
      `FRS_OFF_PCTRL: rd_val = swapped ? {24'h000000, `FRS_PCTRL_NOCBL} :
                                         {28'h0000000, pctrl};
      `FRS_OFF_PSTAT: rd_val = swapped ? {24'h000000, `FRS_PSTAT_NOCBL} :
                                         {24'h000000, printer_status_in};
      default:
      begin
        rd_val = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `FRS_RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= rd_hit ? `FRS_RESP_OKAY : `FRS_RESP_SLVERR;
        s_axi_rvalid  <= 1'b1;
        s_axi_arready <= 1'b0;
      end
      else if (s_axi_rvalid & s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // controller power state machine; direct power-down has top priority except in BUSY, which waits for idle first
  always @*
  begin
    next_fdc_st = fdc_st;
    case (fdc_st)
      `FRS_ST_IDLE:
        if (!pwr[`FRS_PWR_FDC])
          next_fdc_st = `FRS_ST_PD;
        else if (pwr[`FRS_PWR_LOWREQ])
          next_fdc_st = `FRS_ST_APD;
        else if (pwr[`FRS_PWR_FDCAUTO] && fdc_quiet && apd_done)
          next_fdc_st = `FRS_ST_APD;
        else if (!fdc_idle)
          next_fdc_st = `FRS_ST_BUSY;
      `FRS_ST_BUSY:
        if (fdc_idle)
          next_fdc_st = `FRS_ST_IDLE;
      `FRS_ST_APD:
        if (!pwr[`FRS_PWR_FDC])
          next_fdc_st = `FRS_ST_PD;
        else if (fdc_wake)
          next_fdc_st = `FRS_ST_BUSY;
      `FRS_ST_PD:
        if (pwr[`FRS_PWR_FDC])
          next_fdc_st = `FRS_ST_IDLE;
      default:
        next_fdc_st = `FRS_ST_IDLE;
    endcase
  end

  // quiet timer runs only while idle in auto mode; a status access restarts it
  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      fdc_st  <= `FRS_ST_IDLE;
      apd_cnt <= 22'd0;
    end
    else if (ce)
    begin
      fdc_st <= next_fdc_st;
      if (fdc_st != `FRS_ST_IDLE || !pwr[`FRS_PWR_FDCAUTO] || !fdc_quiet ||
          fdc_status_access || apd_done)
        apd_cnt <= 22'd0;
      else
        apd_cnt <= apd_cnt + 22'd1;
    end
  end

  // ==========================================================
  // serial ports: per-direction auto power-down, direct power-down
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_ser
      always @(posedge mclk)
      begin
        if (!reset_n)
        begin
          ser_pd[gi]     <= 1'b0;
          ser_tx_apd[gi] <= 1'b0;
          ser_rx_apd[gi] <= 1'b0;
          sin_prev[gi]   <= serial_input_pin[gi];  // no false edge on release
          ri_prev[gi]    <= ring_indicate[gi];
        end
        else if (ce)
        begin
          sin_prev[gi] <= serial_input_pin[gi];
          ri_prev[gi]  <= ring_indicate[gi];
          if (!pwr[4 + gi] && (ser_tx_empty[gi] || ser_tx_apd[gi]) &&
              (ser_rx_waiting[gi] || ser_rx_apd[gi]))
            ser_pd[gi] <= 1'b1;
          else if (pwr[4 + gi])
            ser_pd[gi] <= 1'b0;
          // wake events win over entry in the same cycle
          if (ser_tx_write[gi] || ri_tog[gi] || !pwr[6 + gi])
            ser_tx_apd[gi] <= 1'b0;
          else if (ser_tx_empty[gi])
            ser_tx_apd[gi] <= 1'b1;
          if (sin_tog[gi] || ri_tog[gi] || !pwr[6 + gi])
            ser_rx_apd[gi] <= 1'b0;
          else if (ser_rx_waiting[gi])
            ser_rx_apd[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // ==========================================================
  // output registers
  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      density_select_out        <= 1'b1;
      data_rate_out             <= 2'b00;
      fdd_ctl_oe                <= 1'b1;
      fdd_head_oe               <= 1'b1;
      fdc_status_n              <= 5'h1F;
      strobe_pin_o              <= 1'b1;
      strobe_pin_oe             <= 1'b0;
      printer_data_bit6_o       <= 1'b1;
      printer_data_bit6_oe      <= 1'b0;
      printer_data_out          <= 8'h00;
      printer_ctrl_out          <= 4'h0;
      lpt_out_oe                <= 1'b0;
      lpt_drq_o                 <= 1'b0;
      lpt_drq_oe                <= 1'b0;
      lpt_irq_o                 <= 1'b0;
      lpt_irq_oe                <= 1'b0;
      lpt_clk_en                <= 1'b1;
      epp_clk_en                <= 1'b1;
      ecp_clk_en                <= 1'b1;
      controller_interrupt_o    <= 1'b0;
      controller_interrupt_oe   <= 1'b1;
      controller_dma_request_o  <= 1'b0;
      controller_dma_request_oe <= 1'b1;
      fdc_power_state           <= `FRS_ST_IDLE;
      fdc_clk_en                <= 1'b1;
      fdc_regs_ro               <= 1'b0;
      ser_clk_en                <= 2'b11;
      ser_regs_ro               <= 2'b00;
      ser_out_inactive          <= 2'b00;
      ser_ri_change             <= 2'b00;
      ir_rx_invert              <= 1'b0;
    end
    else if (ce)
    begin
      // drive side: rate pins, density and swap routing
      data_rate_out      <= cfg[`FRS_CFG_RATE];
      density_select_out <= high_rate ^ cfg[`FRS_CFG_PS2];
      fdd_ctl_oe         <= ~sw_two & ~fdc_apd & ~fdc_pd;
      fdd_head_oe        <= ~sw_two & ~fdc_pd;
      if (sw_one)
        fdc_status_n <= fdd_status_n & lpt_status_n;
      else if (sw_two)
        fdc_status_n <= lpt_status_n;
      else
        fdc_status_n <= fdd_status_n;
      strobe_pin_o         <= sw_two ? fdc_sel1_n : ~pctrl[0];
      strobe_pin_oe        <= sw_two | (~swapped & lpt_out_oe);
      printer_data_bit6_o  <= sw_two ? fdc_motor1_n : printer_data_out[6];
      printer_data_bit6_oe <= sw_two | (~swapped & lpt_out_oe);
      // printer side: data writes take no effect while swapped
      if (!swapped)
        printer_data_out <= pdata;
      printer_ctrl_out <= pctrl;
      lpt_out_oe       <= pwr[`FRS_PWR_LPT] & ~swapped;
      lpt_drq_o        <= swapped ? 1'b0 : lpt_drq_req;
      lpt_drq_oe       <= swapped ? (ecp_configured & cfg[`FRS_CFG_DMAEN]) :
                          (lpt_drq_en & pwr[`FRS_PWR_LPT]);
      lpt_irq_o        <= swapped ? 1'b0 : lpt_irq_req;
      lpt_irq_oe       <= swapped ? cfg[`FRS_CFG_IRQLOW] :
                          (lpt_irq_en & pwr[`FRS_PWR_LPT]);
      lpt_clk_en       <= pwr[`FRS_PWR_LPT];
      epp_clk_en       <= pwr[`FRS_PWR_LPT] &
                          (~pwr[`FRS_PWR_LPTAPD] | epp_used);
      ecp_clk_en       <= pwr[`FRS_PWR_LPT] &
                          (~pwr[`FRS_PWR_LPTAPD] | ecp_used);
      // controller system side
      controller_interrupt_o    <= ~fdc_apd & ~fdc_pd & fdc_irq_req;
      controller_interrupt_oe   <= ~fdc_pd;
      controller_dma_request_o  <= ~fdc_apd & ~fdc_pd & fdc_drq_req;
      controller_dma_request_oe <= ~fdc_pd;
      fdc_power_state           <= fdc_st;
      fdc_clk_en                <= ~fdc_apd & ~fdc_pd;
      fdc_regs_ro               <= fdc_pd;
      // serial side: outputs held inactive, never floated
      ser_clk_en       <= ~ser_pd & ~(ser_tx_apd & ser_rx_apd);
      ser_regs_ro      <= ser_pd;
      ser_out_inactive <= ser_pd | (ser_tx_apd & ser_rx_apd);
      ser_ri_change    <= ri_tog;
      ir_rx_invert     <= cfg[`FRS_CFG_IRPOL];
    end
  end

endmodule

// File: tb/frspc_assertions.sv
/* checker: power-state and swap pin relations of frspc_top.
   bound to frspc_top, sees its ports only. */
`timescale 1ns/1ps
module frspc_assertions (
  // clock, reset, enable, access pulse
  input wire       mclk, reset_n, ce, fdc_status_access,
  // power and serial pins
  input wire [1:0] fdc_power_state, ring_indicate, ser_ri_change,
  input wire [1:0] ser_regs_ro, ser_clk_en, ser_out_inactive,
  // drive and system pins
  input wire       fdd_ctl_oe, fdd_head_oe, strobe_pin_oe, printer_data_bit6_oe, lpt_out_oe,
  input wire       fdc_clk_en, fdc_regs_ro, controller_interrupt_o, controller_interrupt_oe,
  input wire       controller_dma_request_o, controller_dma_request_oe
);
  // ====
  // a stable state is required so pin updates of the same edge have landed
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n || !ce);
  wire apd = fdc_power_state == 2'h2;
  wire pd  = fdc_power_state == 2'h3;
  chk_apd_float: assert property (apd && $stable(fdc_power_state) |-> !fdd_ctl_oe)
    else $error("drive controls driven in apd");
  chk_apd_quiet: assert property (apd && $stable(fdc_power_state)
    |-> controller_interrupt_oe && controller_dma_request_oe && !controller_interrupt_o
    && !controller_dma_request_o) else $error("apd requests not held low");
  chk_pd_float: assert property (pd && $stable(fdc_power_state)
    |-> !controller_interrupt_oe && !controller_dma_request_oe) else $error("pd requests driven");
  chk_pd_clock: assert property (pd && $stable(fdc_power_state)
    |-> !fdc_clk_en && fdc_regs_ro) else $error("pd clock or registers live");
  chk_apd_wake: assert property (apd && fdc_status_access
    |-> ##[1:3] fdc_power_state == 2'h1) else $error("access did not wake apd");
  chk_dual_swap: assert property (strobe_pin_oe && !lpt_out_oe && $stable(lpt_out_oe)
    |-> printer_data_bit6_oe && !fdd_ctl_oe && !fdd_head_oe) else $error("dual swap pins");
  chk_ser_down: assert property (ser_regs_ro[0] && $stable(ser_regs_ro)
    |-> !ser_clk_en[0] && ser_out_inactive[0]) else $error("serial pd not inactive");
  chk_ring_live: assert property ($changed(ring_indicate[0])
    |-> ##[1:2] ser_ri_change[0]) else $error("ring change lost");
endmodule
bind frspc_top frspc_assertions chk_u (.*);

// File: tb/frspc_drive_model.sv
/* floppy drive stand-in: index status toward whichever connector holds it.
   assumes active-low status lines with pull-ups on both connectors. */
`timescale 1ns/1ps
module frspc_drive_model (
  // controls seen from the drive
  input  wire       mclk,
  input  wire       fdd_ctl_oe,
  input  wire       strobe_pin_oe,
  // status back to the block
  output reg  [4:0] fdd_status_n = 5'h1F,
  output reg  [4:0] lpt_status_n = 5'h1F
);
  // ====
  // index toggles while driven; a released connector rests at its pull-ups
  always @(posedge mclk)
  begin
    fdd_status_n <= fdd_ctl_oe ? {4'hF, ~fdd_status_n[0]} : 5'h1F;
    lpt_status_n <= strobe_pin_oe ? {4'hF, ~lpt_status_n[0]} : 5'h1F;
  end
endmodule

// File: tb/frspc_top_tb.sv
/* bench for frspc_top: rate decode rows, swap masking, power states.
   assumes frspc_map.vh on the include path; checker bound by itself. */
`timescale 1ns/1ps
`include "frspc_map.vh"
module frspc_top_tb;
  // ====
  // pins
  logic mclk = '0, reset_n = '0, ce = '1, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0, fdc_idle = '1, fdc_int_pending = '0, lpt_drq_en = '0;
  logic head_unload_expired = '1, fdc_status_access = '0, fdc_soft_reset = '0, fdc_irq_req = '0;
  logic fdc_drq_req = '0, fdc_sel1_n = '1, fdc_motor1_n = '1, epp_configured = '0, lpt_irq_en = '0;
  logic ecp_configured = '0, lpt_drq_req = '0, lpt_irq_req = '0, first_dma_request_pin = '1;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, d;
  logic [7:0] main_status_reg = 8'h80, printer_status_in = 8'h5A;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [2:0] ecr_mode = '0;
  logic [1:0] fdc_motor_en = '0, ser_tx_empty = '0, ser_rx_waiting = 2'h3, ser_tx_write = '0;
  logic [1:0] serial_input_pin = '0, ring_indicate = '0, r;
  wire [31:0] s_axi_rdata;
  wire [7:0] printer_data_out;
  wire [4:0] fdd_status_n, lpt_status_n, fdc_status_n;
  wire [3:0] printer_ctrl_out;
  wire [1:0] s_axi_bresp, s_axi_rresp, data_rate_out, fdc_power_state, ser_clk_en, ser_regs_ro;
  wire [1:0] ser_out_inactive, ser_ri_change;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, density_select_out;
  wire fdd_ctl_oe, fdd_head_oe, strobe_pin_o, strobe_pin_oe, printer_data_bit6_o, lpt_out_oe;
  wire printer_data_bit6_oe, lpt_drq_o, lpt_drq_oe, lpt_irq_o, lpt_irq_oe, lpt_clk_en, epp_clk_en;
  wire ecp_clk_en, controller_interrupt_o, controller_interrupt_oe, controller_dma_request_o;
  wire controller_dma_request_oe, fdc_clk_en, fdc_regs_ro, ir_rx_invert;
  int n_fail = 0, check_count = 0;
  // rows: table, ps2 bit, rate code, expected density
  logic [5:0] rows [9] = '{6'h07, 6'h01, 6'h02, 6'h04, 6'h21, 6'h22, 6'h2B, 6'h38, 6'h12};
  frspc_top #(.APD_CYCLES(20)) dut_u (.*);
  frspc_drive_model drv_u (.mclk(mclk), .fdd_ctl_oe(fdd_ctl_oe), .strobe_pin_oe(strobe_pin_oe),
    .fdd_status_n(fdd_status_n), .lpt_status_n(lpt_status_n));
  always #2 mclk = ~mclk;
  // ====
  // bus and compare tasks
  task automatic chk(input string n, input logic [31:0] s, e);
    check_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge mclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, v, 3'h7};
    do
    begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= '0;
      if (s_axi_wready) s_axi_wvalid <= '0;
    end while (!s_axi_bvalid);
    s_axi_bready <= '0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge mclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do
    begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= '0;
      {d, r} = {s_axi_rdata, s_axi_rresp};
    end while (!s_axi_rvalid);
    s_axi_rready <= '0;
  endtask
  task automatic pw(input logic [31:0] v);
    wr(`FRS_OFF_PWR, v);
    repeat (4) @(posedge mclk);
  endtask
  task automatic report_and_stop;
    if (n_fail == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #200000 n_fail++;
    report_and_stop;
  end
  // ====
  // main sequence
  initial
  begin
    repeat (3) @(posedge mclk);
    reset_n <= '1;
    repeat (3) @(posedge mclk);
    chk("ir invert", ir_rx_invert, 1);
    rd(`FRS_OFF_STAT);
    chk("regdef", d[8], 1);
    foreach (rows[i])
    begin
      wr(`FRS_OFF_CFG, {26'h0, rows[i][5:4], 1'h0, rows[i][3:1]});
      repeat (3) @(posedge mclk);
      chk("density", density_select_out, rows[i][0]);
      chk("rate pins", data_rate_out, rows[i][2:1]);
    end
    wr(`FRS_OFF_CFG, 32'h100);
    wr(`FRS_OFF_PCTRL, 32'hB);
    wr(`FRS_OFF_PDATA, 32'h3C);
    rd(`FRS_OFF_PCTRL);
    chk("ctl read", d, `FRS_PCTRL_NOCBL);
    rd(`FRS_OFF_PSTAT);
    chk("status read", d, `FRS_PSTAT_NOCBL);
    rd(`FRS_OFF_PDATA);
    chk("data read", d, 32'h3C);
    chk("single strobe", {strobe_pin_oe, lpt_drq_oe}, 0);
    wr(`FRS_OFF_CFG, 32'h200);
    repeat (3) @(posedge mclk);
    chk("dual pins", {strobe_pin_oe, fdd_ctl_oe}, 2);
    wr(`FRS_OFF_CFG, 32'h0);
    rd(`FRS_OFF_PCTRL);
    chk("ctl blocked", d, 0);
    rd(12'h0FC);
    chk("unmapped", r, `FRS_RESP_SLVERR);
    pw(32'h133);
    chk("low power", fdc_power_state, `FRS_ST_APD);
    fdc_status_access <= '1;
    @(posedge mclk) fdc_status_access <= '0;
    rd(`FRS_OFF_PWR);
    chk("req cleared", d, 32'h131);
    fdc_idle <= '0;
    pw(32'h130);
    chk("busy holds", fdc_power_state, `FRS_ST_BUSY);
    fdc_idle <= '1;
    repeat (4) @(posedge mclk);
    chk("pd", fdc_power_state, `FRS_ST_PD);
    pw(32'h135);
    fdc_status_access <= '1;
    @(posedge mclk) fdc_status_access <= '0;
    repeat (16) @(posedge mclk);
    chk("auto early", fdc_power_state, `FRS_ST_IDLE);
    repeat (8) @(posedge mclk);
    chk("auto apd", fdc_power_state, `FRS_ST_APD);
    fdc_motor_en <= 2'h1;
    repeat (4) @(posedge mclk);
    chk("motor wake", fdc_power_state == `FRS_ST_APD, 0);
    ring_indicate <= 2'h1;
    pw(32'h121);
    chk("tx busy", ser_regs_ro, 0);
    ser_tx_empty <= 2'h3;
    repeat (4) @(posedge mclk);
    chk("serial pd", ser_regs_ro, 1);
    pw(32'h1A1);
    rd(`FRS_OFF_STAT);
    chk("serial apd", d[7:4], 4'hA);
    {ce, fdc_idle} <= '0;
    repeat (4) @(posedge mclk);
    chk("ce freeze", fdc_power_state, `FRS_ST_IDLE);
    report_and_stop;
  end
endmodule
